// ### design/pmra_top.sv
// Result formatting, calibration, limit compare and alert of a power monitor.
// Assumes raw converter codes arrive from the analogue side, outside this clock domain.
//
// Operation
// - After reset the wide shunt range is used and shunt, bus and temperature convert in turn.
// - Configuration and converter setup return to reset values on every power-up reset.
// - With calibration zero or unwritten, current and power results read zero.
// - Over-current is the shunt result compared with the shunt limit on the same scale.
// - Bus over-voltage is the bus result compared with the bus limit on the same scale.
// - The power limit is compared with the upper 16 bits of the 24-bit power result.
// - All limits revert to their defaults on every power-up reset.
// - Shunt, current, bus and temperature results are two's complement.
// - One power count is 0.2 current counts.
// - A configuration bit selects the 163.84 mV or 40.96 mV shunt range.
// - Power is computed only when a calibration value is present.
// - The alert signals either a selected limit violation or conversion completion.
// - Alert latency depends on when the fault falls within the free-running conversions.
module pmra_top
  import pmra_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
) (
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  input  wire logic          ce,
  input  wire logic          wrEn,
  input  wire pmra_wsel_t    wrSel,
  input  wire logic   [15:0] wrData,
  input  wire logic          rdAck,
  input  wire logic   [15:0] shuntRaw,
  input  wire logic   [15:0] busRaw,
  input  wire logic   [15:0] tempRaw,
  output pmra_results_t      results,
  output logic               convReady,
  output logic        [2:0]  limitFlags,
  output logic               alertN
);

  localparam int CNT_W = $clog2(CONV_CYCLES_P);

  if (CONV_CYCLES_P < 4) begin : g_bad_conv
    $error("CONV_CYCLES_P must be at least 4");
  end

  // ==========================================================================
  // Functions
  function automatic pmra_chan_t nextChan(input pmra_chan_t c, input logic [2:0] m);
    int         base;
    logic [1:0] idx;
    pmra_chan_t r;
    r    = CH_IDLE;
    base = (c == CH_IDLE) ? 2 : int'(c);
    for (int k = 1; k <= 3; k++) begin
      idx = 2'((base + k) % 3);
      if (m[idx] && r == CH_IDLE) begin
        r = pmra_chan_t'(idx);
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Input synchronisers
  // Codes change only between conversions, so a word-wide two-stage sync is adequate here
  logic [15:0] shuntS1_r;
  logic [15:0] shuntS2_r;
  logic [15:0] busS1_r;
  logic [15:0] busS2_r;
  logic [15:0] tempS1_r;
  logic [15:0] tempS2_r;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      shuntS1_r <= 16'h0000;
      shuntS2_r <= 16'h0000;
      busS1_r   <= 16'h0000;
      busS2_r   <= 16'h0000;
      tempS1_r  <= 16'h0000;
      tempS2_r  <= 16'h0000;
    end else if (ce) begin
      shuntS1_r <= shuntRaw;
      shuntS2_r <= shuntS1_r;
      busS1_r   <= busRaw;
      busS2_r   <= busS1_r;
      tempS1_r  <= tempRaw;
      tempS2_r  <= tempS1_r;
    end
  end

  // ==========================================================================
  // Host settings
  pmra_cfg_t   cfg_r;
  pmra_cfg_t   cfg_nxt;
  logic [15:0] cal_r;
  logic [15:0] cal_nxt;
  logic [15:0] sol_r;
  logic [15:0] sol_nxt;
  logic [15:0] bol_r;
  logic [15:0] bol_nxt;
  logic [15:0] pol_r;
  logic [15:0] pol_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    cal_nxt = cal_r;
    sol_nxt = sol_r;
    bol_nxt = bol_r;
    pol_nxt = pol_r;
    if (wrEn) begin
      case (wrSel)
        WR_CFG:  cfg_nxt = pmra_cfg_t'(wrData[CFG_W-1:0]);
        WR_CAL:  cal_nxt = wrData;
        WR_SOL:  sol_nxt = wrData;
        WR_BOL:  bol_nxt = wrData;
        WR_POL:  pol_nxt = wrData;
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cfg_r <= CFG_RST;
      cal_r <= CAL_RST;
      sol_r <= SOL_RST;
      bol_r <= BOL_RST;
      pol_r <= POL_RST;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      cal_r <= cal_nxt;
      sol_r <= sol_nxt;
      bol_r <= bol_nxt;
      pol_r <= pol_nxt;
    end
  end

  // ==========================================================================
  // Conversion sequencer
  // Free running: a fault is seen only at the end of the conversion that samples it
  pmra_chan_t       chan_r;
  pmra_chan_t       chan_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             convDone;

  always_comb begin
    chan_nxt = chan_r;
    cnt_nxt  = cnt_r;
    convDone = 1'b0;
    case (chan_r)
      CH_IDLE: begin
        cnt_nxt  = '0;
        chan_nxt = nextChan(CH_IDLE, cfg_r.convMask);
      end
      default: begin
        if (cnt_r == CNT_W'(CONV_CYCLES_P - 1)) begin
          convDone = 1'b1;
          cnt_nxt  = '0;
          chan_nxt = nextChan(chan_r, cfg_r.convMask);
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      chan_r <= CH_IDLE;
      cnt_r  <= '0;
    end else if (ce) begin
      chan_r <= chan_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  // ==========================================================================
  // Results and limit compare
  logic [15:0]        shunt_r;
  logic [15:0]        shunt_nxt;
  logic [15:0]        bus_r;
  logic [15:0]        bus_nxt;
  logic [15:0]        temp_r;
  logic [15:0]        temp_nxt;
  logic               calcStart_r;
  logic               calcStart_nxt;
  logic [2:0]         flags_r;
  logic [2:0]         flags_nxt;
  logic               ready_r;
  logic               ready_nxt;
  logic               alertN_r;
  logic               alertN_nxt;
  logic [15:0]        current;
  logic [POWER_W-1:0] power;
  logic               calcValid;

  pmra_power_calc u_calc (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .ce       (ce),
    .start    (calcStart_r),
    .shunt    (shunt_r),
    .bus      (bus_r),
    .cal      (cal_r),
    .lowRange (cfg_r.lowRange),
    .current  (current),
    .power    (power),
    .valid    (calcValid)
  );

  always_comb begin
    shunt_nxt     = shunt_r;
    bus_nxt       = bus_r;
    temp_nxt      = temp_r;
    flags_nxt     = flags_r;
    calcStart_nxt = 1'b0;
    if (convDone) begin
      case (chan_r)
        CH_SHUNT: begin
          shunt_nxt     = shuntS2_r;
          calcStart_nxt = 1'b1;
          flags_nxt[0]  = cfg_r.limitEn[0]
                        && ($signed(shuntS2_r) > $signed(sol_r));
        end
        CH_BUS: begin
          bus_nxt       = busS2_r;
          calcStart_nxt = 1'b1;
          flags_nxt[1]  = cfg_r.limitEn[1]
                        && ($signed(busS2_r) > $signed(bol_r));
        end
        CH_TEMP: temp_nxt = tempS2_r;
        default: temp_nxt = temp_r;
      endcase
    end
    if (calcValid) begin
      flags_nxt[2] = cfg_r.limitEn[2]
                   && (power[POWER_LIMIT_SHIFT +: 16] > pol_r);
    end
    flags_nxt = flags_nxt & cfg_r.limitEn;
    // A completion in the same cycle as the host acknowledge keeps the flag set
    ready_nxt  = convDone || (ready_r && !rdAck);
    alertN_nxt = cfg_r.alertOnReady ? !ready_nxt : !(|flags_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      shunt_r     <= 16'h0000;
      bus_r       <= 16'h0000;
      temp_r      <= 16'h0000;
      calcStart_r <= 1'b0;
      flags_r     <= 3'b000;
      ready_r     <= 1'b0;
      alertN_r    <= 1'b1;
    end else if (ce) begin
      shunt_r     <= shunt_nxt;
      bus_r       <= bus_nxt;
      temp_r      <= temp_nxt;
      calcStart_r <= calcStart_nxt;
      flags_r     <= flags_nxt;
      ready_r     <= ready_nxt;
      alertN_r    <= alertN_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign results.shunt   = shunt_r;
  assign results.bus     = bus_r;
  assign results.temp    = temp_r;
  assign results.current = current;
  assign results.power   = power;
  assign convReady       = ready_r;
  assign limitFlags      = flags_r;
  assign alertN          = alertN_r;

endmodule // pmra_top

// ### design/pmra_pkg.sv
// Shared constants and types of the power monitor result and alert logic.
// Assumes a single 125 MHz device clock and a host that writes settings by strobe.
package pmra_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ      = 125;
  localparam int CONV_TIME_US = 50;
  localparam int CONV_CYCLES  = CONV_TIME_US * CLK_MHZ;

  // ==========================================================================
  // Arithmetic scaling
  localparam int CAL_SHIFT         = 11;  // Current = shunt * cal / 2048 in the wide range, shunt * cal / 512 in the narrow range
  localparam int LOW_RANGE_SHIFT   = 2;   // Narrow range has a four times finer shunt step
  localparam int POWER_SHIFT       = 6;   // Power step is 0.2 current step at 3.125 mV bus step
  localparam int POWER_LIMIT_SHIFT = 8;   // Power limit unit is 256 power units
  localparam int POWER_W           = 24;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] CAL_RST = 16'h0000;
  localparam logic [15:0] SOL_RST = 16'h7FFF;
  localparam logic [15:0] BOL_RST = 16'h7FFF;
  localparam logic [15:0] POL_RST = 16'hFFFF;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic       lowRange;      // 0: 163.84 mV range, 1: 40.96 mV range
    logic       alertOnReady;  // 0: limit violation, 1: conversion ready
    logic [2:0] convMask;      // Bit 0 shunt, bit 1 bus, bit 2 temperature
    logic [2:0] limitEn;       // Bit 0 shunt, bit 1 bus, bit 2 power
  } pmra_cfg_t;

  localparam int        CFG_W   = 8;
  localparam pmra_cfg_t CFG_RST = '{lowRange: 1'b0, alertOnReady: 1'b0,
                                    convMask: 3'b111, limitEn: 3'b000};

  typedef enum logic [2:0] {WR_CFG, WR_CAL, WR_SOL, WR_BOL, WR_POL} pmra_wsel_t;

  typedef enum logic [1:0] {CH_SHUNT, CH_BUS, CH_TEMP, CH_IDLE} pmra_chan_t;

  typedef struct packed {
    logic [15:0]        shunt;
    logic [15:0]        bus;
    logic [15:0]        temp;
    logic [15:0]        current;
    logic [POWER_W-1:0] power;
  } pmra_results_t;

endpackage

// ### design/pmra_power_calc.sv
// Current and power arithmetic, registered, started by a one-cycle pulse.
// Assumes its operands stay stable in the cycle of the start pulse.
module pmra_power_calc
  import pmra_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic               ce,
  input  wire logic               start,
  input  wire logic        [15:0] shunt,
  input  wire logic        [15:0] bus,
  input  wire logic        [15:0] cal,
  input  wire logic               lowRange,
  output logic             [15:0] current,
  output logic      [POWER_W-1:0] power,
  output logic                    valid
);

  logic        [15:0] current_r;
  logic        [15:0] current_nxt;
  logic [POWER_W-1:0] power_r;
  logic [POWER_W-1:0] power_nxt;
  logic               valid_r;
  logic               valid_nxt;
  logic signed [34:0] prod;
  logic        [15:0] curMag;
  logic        [31:0] pwrProd;

  // ==========================================================================
  // Arithmetic
  always_comb begin
    prod        = $signed({shunt[15], shunt[15], shunt[15], shunt})
                * $signed({1'b0, cal, 2'b00});
    if (!lowRange) begin
      prod = prod >>> LOW_RANGE_SHIFT;
    end
    current_nxt = current_r;
    power_nxt   = power_r;
    valid_nxt   = 1'b0;
    curMag      = 16'h0000;
    pwrProd     = 32'h0000_0000;
    if (start) begin
      current_nxt = prod[CAL_SHIFT +: 16];
      curMag      = current_nxt[15] ? 16'(-current_nxt) : current_nxt;
      pwrProd     = curMag * (bus[15] ? 16'h0000 : bus);
      power_nxt   = pwrProd[POWER_SHIFT +: POWER_W];
      if (cal == CAL_RST) begin
        current_nxt = 16'h0000;
        power_nxt   = '0;
      end
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      current_r <= 16'h0000;
      power_r   <= '0;
      valid_r   <= 1'b0;
    end else if (ce) begin
      current_r <= current_nxt;
      power_r   <= power_nxt;
      valid_r   <= valid_nxt;
    end
  end

  assign current = current_r;
  assign power   = power_r;
  assign valid   = valid_r;

endmodule // pmra_power_calc

// ### dv/pmra_checker.sv
// Assertions on result, limit and alert timing, bound to the ports of pmra_top.
// Assumes ce stays high; the settings are shadowed here from the write strobe.
module pmra_checker
  import pmra_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
) (
  input wire logic          ref_clk,
  input wire logic          resetn,
  input wire logic          wrEn,
  input wire pmra_wsel_t    wrSel,
  input wire logic   [15:0] wrData,
  input wire logic          rdAck,
  input wire pmra_results_t results,
  input wire logic          convReady,
  input wire logic   [2:0]  limitFlags,
  input wire logic          alertN
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL_WAIT = 3 * CONV_CYCLES_P + 6;
  pmra_cfg_t   cfg_r;
  pmra_cfg_t   cfg_nxt;
  logic [15:0] cal_r;
  logic [15:0] cal_nxt;
  logic [15:0] sol_r;
  logic [15:0] sol_nxt;
  logic [15:0] bol_r;
  logic [15:0] bol_nxt;
  logic [15:0] pol_r;
  logic [15:0] pol_nxt;
  int          calCnt_r;
  int          calCnt_nxt;
  // ==========================================================================
  // Settings shadow
  always_comb begin
    cfg_nxt = cfg_r;
    cal_nxt = cal_r;
    sol_nxt = sol_r;
    bol_nxt = bol_r;
    pol_nxt = pol_r;
    if (wrEn) begin
      case (wrSel)
        WR_CFG: cfg_nxt = pmra_cfg_t'(wrData[CFG_W-1:0]);
        WR_CAL: cal_nxt = wrData;
        WR_SOL: sol_nxt = wrData;
        WR_BOL: bol_nxt = wrData;
        WR_POL: pol_nxt = wrData;
        default: cfg_nxt = cfg_r;
      endcase
    end
    // Long enough for a full round plus the arithmetic delay
    calCnt_nxt = (cal_r != 16'h0000) ? 0 : ((calCnt_r < CAL_WAIT) ? calCnt_r + 1 : calCnt_r);
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cfg_r    <= CFG_RST;
      cal_r    <= CAL_RST;
      sol_r    <= SOL_RST;
      bol_r    <= BOL_RST;
      pol_r    <= POL_RST;
      calCnt_r <= 0;
    end else begin
      cfg_r    <= cfg_nxt;
      cal_r    <= cal_nxt;
      sol_r    <= sol_nxt;
      bol_r    <= bol_nxt;
      pol_r    <= pol_nxt;
      calCnt_r <= calCnt_nxt;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  chk_reset_idle: assert property (
    $rose(resetn) |-> !convReady && alertN && limitFlags == 3'b000)
    else $error("outputs not idle after reset");
  chk_alert_limit: assert property (
    $changed(limitFlags) && !$past(cfg_r.alertOnReady) |-> alertN == ~|limitFlags)
    else $error("alert does not follow limit flags");
  chk_alert_ready: assert property (
    $rose(convReady) && $past(cfg_r.alertOnReady) |-> ##[0:1] !alertN)
    else $error("alert missing on conversion ready");
  chk_ready_clear: assert property (
    $fell(convReady) |-> $past(rdAck))
    else $error("ready dropped without acknowledge");
  chk_cal_zero: assert property (
    calCnt_r == CAL_WAIT |-> results.current == 16'h0000 && results.power == '0)
    else $error("current result without calibration");
  chk_flag_enabled: assert property (
    (limitFlags & ~$past(limitFlags) & ~$past(cfg_r.limitEn)) == 3'b000)
    else $error("flag raised for a disabled limit");
  chk_shunt_cmp: assert property (
    $rose(limitFlags[0]) |-> $signed(results.shunt) > $signed($past(sol_r)))
    else $error("shunt flag without excess");
  chk_bus_cmp: assert property (
    $rose(limitFlags[1]) |-> $signed(results.bus) > $signed($past(bol_r)))
    else $error("bus flag without excess");
  chk_power_cmp: assert property (
    $rose(limitFlags[2]) |-> results.power[POWER_W-1:POWER_LIMIT_SHIFT] > $past(pol_r))
    else $error("power flag without excess");
  cov_power_flag: cover property ($rose(limitFlags[2]));
  cov_ready_ack: cover property ($fell(convReady));
  cov_alert_low: cover property ($fell(alertN));
endmodule // pmra_checker

bind pmra_top pmra_checker #(.CONV_CYCLES_P(CONV_CYCLES_P)) chk (
  .ref_clk   (ref_clk),
  .resetn    (resetn),
  .wrEn      (wrEn),
  .wrSel     (wrSel),
  .wrData    (wrData),
  .rdAck     (rdAck),
  .results   (results),
  .convReady (convReady),
  .limitFlags(limitFlags),
  .alertN    (alertN)
);

// ### dv/pmra_host.sv
// Host model: writes settings and acknowledges results, one strobe per request.
// Assumes the caller waits for completion; requests change 1 ns after an edge.
module pmra_host
  import pmra_pkg::*;
(
  input  wire logic   ref_clk,
  output logic        wrEn,
  output pmra_wsel_t  wrSel,
  output logic [15:0] wrData,
  output logic        rdAck
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wrEn   = 1'b0;
    wrSel  = WR_CFG;
    wrData = 16'h0000;
    rdAck  = 1'b0;
  end
  // Released data is inverted so a stale value is never mistaken for a write
  task automatic put(input pmra_wsel_t sel, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    wrEn   = 1'b1;
    wrSel  = sel;
    wrData = d;
    @(posedge ref_clk);
    #1;
    wrEn   = 1'b0;
    wrData = ~d;
  endtask
  task automatic ack();
    @(posedge ref_clk);
    #1;
    rdAck = 1'b1;
    @(posedge ref_clk);
    #1;
    rdAck = 1'b0;
  endtask
endmodule // pmra_host

// ### dv/tb_pmra_top.sv
// Self-checking bench of the power monitor result and alert logic.
// Assumes a short conversion of 8 cycles; ce is held high throughout.
module tb_pmra_top;
  import pmra_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CC = 8;
  logic          ref_clk  = 1'b0;
  logic          resetn   = 1'b0;
  logic   [15:0] shuntRaw = 16'h0800;
  logic   [15:0] busRaw   = 16'h3C00;
  logic   [15:0] tempRaw  = 16'h00C8;
  logic          wrEn, rdAck, convReady, alertN;
  pmra_wsel_t    wrSel;
  logic   [15:0] wrData;
  pmra_results_t results;
  logic   [2:0]  limitFlags;
  int            fails    = 0;
  int            checks   = 0;
  always #4 ref_clk = ~ref_clk;
  pmra_host host (.ref_clk(ref_clk), .wrEn(wrEn), .wrSel(wrSel), .wrData(wrData), .rdAck(rdAck));
  pmra_top #(.CONV_CYCLES_P(CC)) uut (
    .ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .wrEn(wrEn), .wrSel(wrSel),
    .wrData(wrData), .rdAck(rdAck), .shuntRaw(shuntRaw), .busRaw(busRaw),
    .tempRaw(tempRaw), .results(results), .convReady(convReady),
    .limitFlags(limitFlags), .alertN(alertN));
  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic powerUp();
    @(posedge ref_clk);
    #1 resetn = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 resetn = 1'b1;
  endtask
  // A full round of three channels plus the arithmetic delay
  task automatic settle();
    repeat (3 * CC + 6) @(posedge ref_clk);
    #1;
  endtask
  task automatic waitReady();
    int n = 0;
    while (convReady !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 4 * CC) begin
        fails++;
        $display("MISMATCH convReady expected 1 seen %b", convReady);
        conclude();
      end
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic testDefaults();
    check("alertN", 24'(alertN), 24'h1);
    check("power", results.power, 24'h0);
    settle();
    check("shunt", 24'(results.shunt), 24'h0800);
    check("bus", 24'(results.bus), 24'h3C00);
    check("temp", 24'(results.temp), 24'h00C8);
    check("current", 24'(results.current), 24'h0);
    check("power", results.power, 24'h0);
    // All three channels stay converting; all three limits enabled
    host.put(WR_CFG, 16'h003F);
    settle();
    check("flags", 24'(limitFlags), 24'h0);
    $display("test defaults done");
  endtask
  task automatic testCalc();
    host.put(WR_CAL, 16'h0FD2);
    settle();
    check("current", 24'(results.current), 24'h0FD2);
    check("power", results.power, 24'h0E_D4E0);
    host.put(WR_CFG, 16'h00BF);
    settle();
    check("current narrow", 24'(results.current), 24'h3F48);
    check("power narrow", results.power, 24'h3B_5380);
    shuntRaw = 16'hB410;
    tempRaw  = 16'hFF38;
    host.put(WR_CFG, 16'h003F);
    settle();
    check("shunt neg", 24'(results.shunt), 24'hB410);
    check("temp neg", 24'(results.temp), 24'hFF38);
    shuntRaw = 16'h0800;
    tempRaw  = 16'h00C8;
    $display("test calc done");
  endtask
  task automatic testLimits();
    host.put(WR_SOL, 16'h07FF);
    host.put(WR_BOL, 16'h3BFF);
    host.put(WR_POL, 16'h0ED3);
    settle();
    check("flags over", 24'(limitFlags), 24'h7);
    check("alertN over", 24'(alertN), 24'h0);
    host.put(WR_SOL, 16'h0800);
    host.put(WR_BOL, 16'h3C00);
    host.put(WR_POL, 16'h0ED4);
    settle();
    check("flags equal", 24'(limitFlags), 24'h0);
    check("alertN equal", 24'(alertN), 24'h1);
    $display("test limits done");
  endtask
  task automatic testReady();
    host.put(WR_CFG, 16'h0078);
    host.ack();
    waitReady();
    @(posedge ref_clk);
    #1;
    check("alertN ready", 24'(alertN), 24'h0);
    host.ack();
    check("convReady", 24'(convReady), 24'h0);
    @(posedge ref_clk);
    #1;
    check("alertN acked", 24'(alertN), 24'h1);
    $display("test ready done");
  endtask
  // Bus-only conversions: a small excess must show within 1.5 conversion times
  task automatic testLatency();
    int n;
    host.put(WR_CFG, 16'h0012);
    settle();
    check("alertN quiet", 24'(alertN), 24'h1);
    busRaw = 16'h3C01;
    n = 0;
    while (alertN !== 1'b0 && n < 3 * CC / 2) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("alertN latency", 24'(alertN), 24'h0);
    check("flags bus", 24'(limitFlags), 24'h2);
    busRaw = 16'h3C00;
    settle();
    check("alertN cleared", 24'(alertN), 24'h1);
    $display("test latency done");
  endtask
  task automatic testPowerCycle();
    host.put(WR_SOL, 16'h0000);
    powerUp();
    settle();
    check("current", 24'(results.current), 24'h0);
    check("flags", 24'(limitFlags), 24'h0);
    check("alertN mode", 24'(alertN), 24'h1);
    host.put(WR_CFG, 16'h003F);
    settle();
    check("flags", 24'(limitFlags), 24'h0);
    $display("test power cycle done");
  endtask
  initial begin
    powerUp();
    testDefaults();
    testCalc();
    testLimits();
    testReady();
    testLatency();
    testPowerCycle();
    conclude();
  end
endmodule // tb_pmra_top
